//--- src/pfbc_top.sv
/*
  Per-generator fault, current-limit, leading-edge blanking, trigger
  compare, time-base capture, chop clock and high-resolution enables.
  Assumes the PWM core supplies its raw outputs, time bases and a period
  start pulse, all synchronous to core_clk; register port reads answer
  one cycle after the read strobe.
*/
// The register offsets and the strobed register port were chosen for this implementation.
// How it works
// - Five-bit fault source picks one of eight
// - Fault polarity bit one means active low
// - Fault mode 11 ignores the fault input
// - Mode 01 forces outputs cycle by cycle
// - Mode 00 forces outputs and latches them
// - Primary compare match issues an ADC trigger
// - Secondary compare match triggers; low bits zero
// - Enabled output edges start the blanking counter
// - Fault blanking masks fault during window
// - Limit blanking masks limit during window
// - Blanking length counts in whole-cycle steps: the 8.32 ns step is rounded up to one 10 ns cycle
// - Limit leading edge captures primary time base
// - Capture uses limit input, after blanking
// - Chop generator runs only while enabled
// - Chop frequency follows divider and prescale
// - Auxiliary bit 15 enables high-resolution period
// - Auxiliary bit 14 enables high-resolution duty
// - Chop source selects generator or high outputs
// - Separate chop enables for high and low
// - Independent mode: limit forces high, fault low
// - Limit input forces outputs only while enabled
module pfbc_top
  import pfbc_pkg::*;
#(
  parameter int FAULT_INPUTS = 8,
  parameter int BLANK_W = 8,
  parameter int CHOP_W = 15
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [FAULT_INPUTS-1:0] fault_in,
  input wire logic pwm_high_in,
  input wire logic pwm_low_in,
  input wire logic pwm_period_start,
  input wire logic [15:0] time_base,
  input wire logic [15:0] secondary_time_base,
  input wire logic primary_local_tb,
  input wire logic secondary_local_tb,
  input wire logic [2:0] chop_peer_high,
  input wire logic [2:0] pwm_clock_prescale,
  output logic high_output,
  output logic low_output,
  output logic adc_trigger_primary,
  output logic adc_trigger_secondary,
  output logic hires_period_en,
  output logic hires_duty_en
);

  // Software visible registers
  pfbc_flc_t flc_r; // Fault and current-limit control
  logic [15:0] trig_pri_r; // Primary trigger compare
  logic [15:0] trig_sec_r; // Secondary trigger compare
  pfbc_blank_t blank_r; // Blanking control
  logic [15:0] capture_r; // Captured time base, read only
  logic [15:0] chop_r; // Chop clock control
  logic [15:0] aux_r; // Auxiliary control
  logic [15:0] out_data_r; // Fault and limit output states
  logic [15:0] rdata_r; // Read data, one cycle after the strobe

  // Internal signals
  logic fault_sel_raw; // Selected fault input, raw
  logic fault_active; // After polarity
  logic fault_q; // After blanking
  logic limit_sel_raw; // Selected limit input, raw
  logic limit_active; // After polarity
  logic limit_q; // After blanking
  logic limit_q_d; // Previous limit_q, for edge detect
  logic limit_edge; // Leading edge of the blanked limit input
  logic fault_mode_on; // Fault mode is 00 or 01
  logic fault_hit; // Active fault that the mode acts on
  logic limit_hit; // Active limit that the mode acts on
  logic fault_force; // Fault forcing is in effect
  logic limit_force; // Limit forcing is in effect
  pfbc_fstate_t fs_r, fs_nxt; // Fault force state
  logic limit_hold_r; // Limit force held to the period end
  logic high_d, low_d; // Previous raw outputs
  logic blank_start; // Enabled edge seen this cycle
  logic blank_busy; // Blanking window open
  logic [BLANK_W-1:0] blank_len; // Blanking count in cycles
  logic chop_busy; // Chop half period still running
  logic [CHOP_W-1:0] chop_half; // Chop half period in cycles
  logic chop_gen_r; // Chop generator output
  logic chop_sig; // Selected chop signal
  logic high_chopped, low_chopped; // Outputs after chopping
  logic high_nxt, low_nxt; // Outputs after forcing
  logic high_r, low_r; // Registered outputs
  logic pri_match, sec_match; // Compare matches
  logic pri_match_d, sec_match_d; // Previous matches
  logic trig_pri_r_out, trig_sec_r_out; // Trigger pulses

  // Register writes; reserved bits are masked to zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flc_r <= pfbc_flc_t'(PFBC_RST_REG);
      trig_pri_r <= PFBC_RST_REG;
      trig_sec_r <= PFBC_RST_REG;
      blank_r <= pfbc_blank_t'(PFBC_RST_REG);
      chop_r <= PFBC_RST_REG;
      aux_r <= PFBC_RST_REG;
      out_data_r <= PFBC_RST_REG;
    end else if (reg_wr) begin
      unique case (reg_addr)
        PFBC_IDX_FLT_LIMIT: flc_r <= pfbc_flc_t'(reg_wdata & PFBC_MASK_FULL);
        PFBC_IDX_TRIG_PRI: trig_pri_r <= reg_wdata & PFBC_MASK_UPPER13;
        PFBC_IDX_TRIG_SEC: trig_sec_r <= reg_wdata & PFBC_MASK_UPPER13;
        PFBC_IDX_BLANK: blank_r <= pfbc_blank_t'(reg_wdata & PFBC_MASK_UPPER13);
        PFBC_IDX_CHOP: chop_r <= reg_wdata & PFBC_MASK_CHOP;
        PFBC_IDX_AUX: aux_r <= reg_wdata & PFBC_MASK_AUX;
        PFBC_IDX_OUT_DATA: out_data_r <= reg_wdata & PFBC_MASK_OUT_DATA;
        // Capture register is read only; writes are dropped
        PFBC_IDX_CAPTURE: begin
        end
      endcase
    end
  end

  // Read data for the cycle after a read strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= PFBC_RST_REG;
    end else if (reg_rd) begin
      unique case (reg_addr)
        PFBC_IDX_FLT_LIMIT: rdata_r <= 16'(flc_r);
        PFBC_IDX_TRIG_PRI: rdata_r <= trig_pri_r;
        PFBC_IDX_TRIG_SEC: rdata_r <= trig_sec_r;
        PFBC_IDX_BLANK: rdata_r <= 16'(blank_r);
        PFBC_IDX_CAPTURE: rdata_r <= capture_r;
        PFBC_IDX_CHOP: rdata_r <= chop_r;
        PFBC_IDX_AUX: rdata_r <= aux_r;
        // Output states plus live force status
        PFBC_IDX_OUT_DATA: begin
          rdata_r <= out_data_r;
          rdata_r[PFBC_POS_FAULT_FORCED] <= fault_force;
          rdata_r[PFBC_POS_LIMIT_FORCED] <= limit_force;
        end
      endcase
    end else begin
      rdata_r <= PFBC_RST_REG;
    end
  end

  assign reg_rdata = rdata_r;

  // Source selection; reserved codes select nothing
  always_comb begin
    fault_sel_raw = 1'b0;
    limit_sel_raw = 1'b0;
    if (flc_r.fault_source_sel < PFBC_SRC_FIRST_RSVD) begin
      fault_sel_raw = fault_in[flc_r.fault_source_sel[2:0]];
    end
    if (flc_r.limit_source_sel < PFBC_SRC_FIRST_RSVD) begin
      limit_sel_raw = fault_in[flc_r.limit_source_sel[2:0]];
    end
  end

  // Polarity: a set bit inverts to an active-low source
  assign fault_active = fault_sel_raw ^ flc_r.fault_polarity;
  assign limit_active = limit_sel_raw ^ flc_r.limit_polarity;

  // Blanking masks each input only when its enable is set
  assign fault_q = fault_active &
    !(blank_r.fault_blank_enable & blank_busy);
  assign limit_q = limit_active &
    !(blank_r.limit_blank_enable & blank_busy);

  // Edge history of the raw PWM outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      high_d <= 1'b0;
      low_d <= 1'b0;
    end else begin
      high_d <= pwm_high_in;
      low_d <= pwm_low_in;
    end
  end

  // Any enabled edge restarts the blanking window
  assign blank_start =
    (blank_r.high_rise_blank_en & pwm_high_in & !high_d) |
    (blank_r.high_fall_blank_en & !pwm_high_in & high_d) |
    (blank_r.low_rise_blank_en & pwm_low_in & !low_d) |
    (blank_r.low_fall_blank_en & !pwm_low_in & low_d);

  // Window length scales the seven-bit field by the step
  assign blank_len = BLANK_W'(blank_r.blanking_length *
    PFBC_BLANK_STEP_CYC);

  // Blanking window counter
  pfbc_down_counter #(.W(BLANK_W)) u_blank_cnt (
    .core_clk(core_clk),
    .reset(reset),
    .load(blank_start),
    .load_value(blank_len),
    .busy(blank_busy)
  );

  // Fault acts only in modes 00 and 01; 10 and 11 ignore it
  assign fault_mode_on = (flc_r.fault_mode_sel == PFBC_FMODE_LATCH) ||
    (flc_r.fault_mode_sel == PFBC_FMODE_CYCLE);
  assign fault_hit = fault_q & fault_mode_on;
  assign limit_hit = limit_q & flc_r.limit_mode_enable;

  // Fault state: a new fault wins over the period release
  always_comb begin
    fs_nxt = fs_r;
    if (!fault_mode_on) begin
      fs_nxt = PFBC_FS_IDLE;
    end else if (fault_hit) begin
      if (flc_r.fault_mode_sel == PFBC_FMODE_LATCH) begin
        fs_nxt = PFBC_FS_LATCH;
      end else begin
        fs_nxt = PFBC_FS_CYCLE;
      end
    end else begin
      unique case (fs_r)
        PFBC_FS_IDLE: fs_nxt = PFBC_FS_IDLE;
        // Release at the next period start once the fault is gone
        PFBC_FS_CYCLE: begin
          if (pwm_period_start) begin
            fs_nxt = PFBC_FS_IDLE;
          end
        end
        PFBC_FS_LATCH: fs_nxt = PFBC_FS_LATCH;
      endcase
    end
  end

  // Fault state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fs_r <= PFBC_FS_IDLE;
    end else begin
      fs_r <= fs_nxt;
    end
  end

  // Limit force holds to the end of the current period
  always_ff @(posedge core_clk) begin
    if (reset) begin
      limit_hold_r <= 1'b0;
    end else if (limit_hit) begin
      limit_hold_r <= 1'b1;
    end else if (pwm_period_start || !flc_r.limit_mode_enable) begin
      limit_hold_r <= 1'b0;
    end
  end

  assign fault_force = fault_hit | (fs_r != PFBC_FS_IDLE);
  assign limit_force = limit_hit | limit_hold_r;

  // Capture the primary time base on a blanked limit leading edge
  assign limit_edge = limit_q & !limit_q_d;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      limit_q_d <= 1'b0;
      capture_r <= PFBC_RST_REG;
    end else begin
      limit_q_d <= limit_q;
      if (limit_edge) begin
        capture_r <= time_base & PFBC_MASK_UPPER13;
      end
    end
  end

  // Chop half period from divider and prescale
  assign chop_half = CHOP_W'(((CHOP_W'(chop_r[9:3]) + CHOP_W'(1))
    << pwm_clock_prescale) * PFBC_CHOP_HALF_CYC);

  // Chop period counter; held idle while the generator is off
  pfbc_down_counter #(.W(CHOP_W)) u_chop_cnt (
    .core_clk(core_clk),
    .reset(reset),
    .load(chop_r[PFBC_POS_CHOP_EN] & !chop_busy),
    .load_value(chop_half - CHOP_W'(1)),
    .busy(chop_busy)
  );

  // Chop generator toggles at each half period end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      chop_gen_r <= 1'b0;
    end else if (!chop_r[PFBC_POS_CHOP_EN]) begin
      chop_gen_r <= 1'b0;
    end else if (!chop_busy) begin
      chop_gen_r <= !chop_gen_r;
    end
  end

  // Chop source; reserved codes leave outputs unchopped
  always_comb begin
    unique case (aux_r[PFBC_POS_CHOP_SEL +: 4])
      PFBC_CHOP_GEN: chop_sig = chop_gen_r;
      PFBC_CHOP_GEN1_HIGH: chop_sig = chop_peer_high[0];
      PFBC_CHOP_GEN2_HIGH: chop_sig = chop_peer_high[1];
      PFBC_CHOP_GEN4_HIGH: chop_sig = chop_peer_high[2];
      default: chop_sig = 1'b1;
    endcase
  end

  // Each output is gated only while its own enable is set
  assign high_chopped = pwm_high_in &
    (chop_sig | !aux_r[PFBC_POS_CHOP_HIGH]);
  assign low_chopped = pwm_low_in &
    (chop_sig | !aux_r[PFBC_POS_CHOP_LOW]);

  // Forcing after chopping; fault has priority in normal mode
  always_comb begin
    high_nxt = high_chopped;
    low_nxt = low_chopped;
    if (flc_r.independent_fault_enable) begin
      // Limit owns the high side, fault owns the low side
      if (limit_force) begin
        high_nxt = out_data_r[1];
      end
      if (fault_force) begin
        low_nxt = out_data_r[0];
      end
    end else begin
      if (limit_force) begin
        high_nxt = out_data_r[3];
        low_nxt = out_data_r[2];
      end
      if (fault_force) begin
        high_nxt = out_data_r[1];
        low_nxt = out_data_r[0];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      high_r <= 1'b0;
      low_r <= 1'b0;
    end else begin
      high_r <= high_nxt;
      low_r <= low_nxt;
    end
  end

  // Trigger compares on the 13-bit upper fields
  assign pri_match = primary_local_tb &&
    (time_base[15:3] == trig_pri_r[15:3]);
  assign sec_match = secondary_local_tb &&
    (secondary_time_base[15:3] == trig_sec_r[15:3]);

  // One trigger pulse at the start of each match
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pri_match_d <= 1'b0;
      sec_match_d <= 1'b0;
      trig_pri_r_out <= 1'b0;
      trig_sec_r_out <= 1'b0;
    end else begin
      pri_match_d <= pri_match;
      sec_match_d <= sec_match;
      trig_pri_r_out <= pri_match & !pri_match_d;
      trig_sec_r_out <= sec_match & !sec_match_d;
    end
  end

  assign high_output = high_r;
  assign low_output = low_r;
  assign adc_trigger_primary = trig_pri_r_out;
  assign adc_trigger_secondary = trig_sec_r_out;
  assign hires_period_en = aux_r[PFBC_POS_HIRES_PER];
  assign hires_duty_en = aux_r[PFBC_POS_HIRES_DUTY];

  // Checks on the block's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_blank_arm;
    blank_start && blank_len == BLANK_W'(2) ##1 !blank_start [*2];
  endsequence

  a_src_reserved: assert property (
    flc_r.fault_source_sel >= PFBC_SRC_FIRST_RSVD |-> !fault_sel_raw)
    else $error("reserved fault source selected an input");
  a_fault_low: assert property (
    flc_r.fault_polarity && !fault_sel_raw |-> fault_active)
    else $error("active-low fault not seen as active");
  a_mode_off: assert property (
    flc_r.fault_mode_sel == PFBC_FMODE_OFF |=> fs_r == PFBC_FS_IDLE)
    else $error("disabled fault mode still forcing");
  a_cycle_hold: assert property (
    fs_r == PFBC_FS_CYCLE && !pwm_period_start &&
    flc_r.fault_mode_sel == PFBC_FMODE_CYCLE |=> fs_r == PFBC_FS_CYCLE)
    else $error("cycle fault released before period start");
  a_latch_hold: assert property (
    fs_r == PFBC_FS_LATCH && flc_r.fault_mode_sel == PFBC_FMODE_LATCH
    |=> fs_r == PFBC_FS_LATCH)
    else $error("latched fault released");
  a_trig_pulse: assert property (
    pri_match && !pri_match_d |=> adc_trigger_primary ##1 !adc_trigger_primary)
    else $error("primary trigger pulse wrong");
  a_sec_low_zero: assert property (
    reg_rd && reg_addr == PFBC_IDX_TRIG_SEC |=> reg_rdata[2:0] == 3'h0)
    else $error("secondary compare low bits not zero");
  a_fault_blank: assert property (
    blank_r.fault_blank_enable && blank_busy |-> !fault_q)
    else $error("fault passed during blanking");
  a_blank_len: assert property (
    s_blank_arm |=> !blank_busy)
    else $error("blanking window longer than its length");
  a_blank_win: assert property (
    s_blank_arm |-> blank_busy && $past(blank_busy))
    else $error("blanking window not two cycles");
  a_capture: assert property (
    limit_edge |=> capture_r[15:3] == $past(time_base[15:3]))
    else $error("time base not captured");
  a_chop_stop: assert property (
    !chop_r[PFBC_POS_CHOP_EN] |=> !chop_gen_r)
    else $error("chop generator running while disabled");

endmodule

//--- src/pfbc_pkg.sv
/*
  Shared constants and types for the PWM fault, blanking and chop logic:
  register indices, field positions, reset values, write masks, timing
  constants and the fault state machine encoding.
  Assumes a single 100 MHz core clock and a 16-bit register port.
*/
package pfbc_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] PFBC_IDX_FLT_LIMIT = 3'h0;
  localparam logic [2:0] PFBC_IDX_TRIG_PRI = 3'h1;
  localparam logic [2:0] PFBC_IDX_TRIG_SEC = 3'h2;
  localparam logic [2:0] PFBC_IDX_BLANK = 3'h3;
  localparam logic [2:0] PFBC_IDX_CAPTURE = 3'h4;
  localparam logic [2:0] PFBC_IDX_CHOP = 3'h5;
  localparam logic [2:0] PFBC_IDX_AUX = 3'h6;
  localparam logic [2:0] PFBC_IDX_OUT_DATA = 3'h7;

  // Reset values (all registers clear)
  localparam logic [15:0] PFBC_RST_REG = 16'h0000;

  // Writable bit masks; other bits read as zero, except the force status bits 15 and 14 of output data
  localparam logic [15:0] PFBC_MASK_FULL = 16'hFFFF;
  localparam logic [15:0] PFBC_MASK_UPPER13 = 16'hFFF8;
  localparam logic [15:0] PFBC_MASK_CHOP = 16'h83F8;
  localparam logic [15:0] PFBC_MASK_AUX = 16'hC03F;
  localparam logic [15:0] PFBC_MASK_OUT_DATA = 16'h000F;

  // Field positions
  localparam int PFBC_POS_VALUE_LSB = 3;
  localparam int PFBC_POS_CHOP_EN = 15;
  localparam int PFBC_POS_HIRES_PER = 15;
  localparam int PFBC_POS_HIRES_DUTY = 14;
  localparam int PFBC_POS_CHOP_SEL = 2;
  localparam int PFBC_POS_CHOP_HIGH = 1;
  localparam int PFBC_POS_CHOP_LOW = 0;
  localparam int PFBC_POS_FAULT_FORCED = 15;
  localparam int PFBC_POS_LIMIT_FORCED = 14;

  // Fault source codes at or above this value are reserved
  localparam logic [4:0] PFBC_SRC_FIRST_RSVD = 5'h08;

  // Fault mode codes
  localparam logic [1:0] PFBC_FMODE_LATCH = 2'h0;
  localparam logic [1:0] PFBC_FMODE_CYCLE = 2'h1;
  localparam logic [1:0] PFBC_FMODE_RSVD = 2'h2;
  localparam logic [1:0] PFBC_FMODE_OFF = 2'h3;

  // Chop source codes
  localparam logic [3:0] PFBC_CHOP_GEN = 4'h0;
  localparam logic [3:0] PFBC_CHOP_GEN1_HIGH = 4'h1;
  localparam logic [3:0] PFBC_CHOP_GEN2_HIGH = 4'h2;
  localparam logic [3:0] PFBC_CHOP_GEN4_HIGH = 4'h4;

  // Timing: core clock period and the documented step sizes, in ps
  localparam int PFBC_CLK_PERIOD_PS = 10000;
  localparam int PFBC_BLANK_STEP_PS = 8320;
  localparam int PFBC_CHOP_STEP_PS = 16640;
  // Blanking step, a least time, rounded up to whole cycles
  localparam int PFBC_BLANK_STEP_CYC =
    (PFBC_BLANK_STEP_PS + PFBC_CLK_PERIOD_PS - 1) / PFBC_CLK_PERIOD_PS;
  // Half of one chop step, rounded up, never below one cycle
  localparam int PFBC_CHOP_HALF_CYC =
    (PFBC_CHOP_STEP_PS / 2 + PFBC_CLK_PERIOD_PS - 1) / PFBC_CLK_PERIOD_PS;

  // Fault and current-limit control register layout
  typedef struct packed {
    logic independent_fault_enable; // Bit 15
    logic [4:0] limit_source_sel; // Bits 14-10
    logic limit_polarity; // Bit 9
    logic limit_mode_enable; // Bit 8
    logic [4:0] fault_source_sel; // Bits 7-3
    logic fault_polarity; // Bit 2
    logic [1:0] fault_mode_sel; // Bits 1-0
  } pfbc_flc_t;

  // Blanking control register layout
  typedef struct packed {
    logic high_rise_blank_en; // Bit 15
    logic high_fall_blank_en; // Bit 14
    logic low_rise_blank_en; // Bit 13
    logic low_fall_blank_en; // Bit 12
    logic fault_blank_enable; // Bit 11
    logic limit_blank_enable; // Bit 10
    logic [6:0] blanking_length; // Bits 9-3
    logic [2:0] unused; // Bits 2-0, read zero
  } pfbc_blank_t;

  // Fault force state, one-hot
  typedef enum logic [2:0] {
    PFBC_FS_IDLE = 3'b001,
    PFBC_FS_CYCLE = 3'b010,
    PFBC_FS_LATCH = 3'b100
  } pfbc_fstate_t;

endpackage

//--- src/pfbc_down_counter.sv
/*
  Loadable down counter used for the blanking window and the chop clock.
  Assumes load has priority over counting and that a zero count is idle.
*/
module pfbc_down_counter #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  output logic busy
);

  // Remaining count
  logic [W-1:0] count_r;

  // Load or count down to zero, then hold
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= load_value;
    end else if (count_r != '0) begin
      count_r <= count_r - W'(1);
    end
  end

  // Busy while any count remains
  assign busy = (count_r != '0);

endmodule

//--- verification/pfbc_pwm_partner.sv
/*
  Behavioural PWM core that feeds the protection block: a free running
  time base, a period start pulse and complementary raw outputs.
  Assumes one core clock and a synchronous active high reset.
*/
module pfbc_pwm_partner #(
  parameter int PERIOD = 64,
  parameter int DUTY = 24
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic [15:0] time_base,
  output logic period_start,
  output logic pwm_high,
  output logic pwm_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Time base wraps at the period end
  always_ff @(posedge core_clk) begin
    if (reset || time_base == 16'(PERIOD - 1)) begin
      time_base <= 16'h0000;
    end else begin
      time_base <= time_base + 16'h0001;
    end
  end
  // Pulse while the count sits at zero
  assign period_start = (time_base == 16'h0000);
  // High for the first DUTY counts, low is its complement
  assign pwm_high = (time_base < 16'(DUTY));
  assign pwm_low = !pwm_high;
endmodule

//--- verification/pwm_fault_blank_chop_logic_test.sv
/*
  Self-checking bench for pfbc_top with a behavioural PWM core.
  Assumes pfbc_pkg and pfbc_pwm_partner are compiled before it.
*/
module pwm_fault_blank_chop_logic_test;
  import pfbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 0, chop_peer = 0;
  logic [15:0] reg_wdata = 0, rdv, tb, reg_rdata;
  logic [7:0] fault_drive = 0;
  logic loc_p = 0, loc_s = 0, ph, pl, ps;
  logic high_output, low_output, trg_p, trg_s, hr_p, hr_d;
  int err_total = 0, checked = 0, c_hi, c_lo, c_p, c_s;
  logic [31:0] seed = 32'd30274;
  // Clock of 10 ns
  always #5 core_clk = ~core_clk;
  // Duty of 22 puts the high falling edge just before a step of 8
  pfbc_pwm_partner #(.DUTY(22)) pm (.core_clk, .reset, .time_base(tb),
    .period_start(ps), .pwm_high(ph), .pwm_low(pl));
  pfbc_top dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .fault_in(fault_drive), .pwm_high_in(ph),
    .pwm_low_in(pl), .pwm_period_start(ps), .time_base(tb),
    .secondary_time_base(tb), .primary_local_tb(loc_p),
    .secondary_local_tb(loc_s), .chop_peer_high(chop_peer),
    .pwm_clock_prescale(3'h0), .high_output, .low_output,
    .adc_trigger_primary(trg_p), .adc_trigger_secondary(trg_s),
    .hires_period_en(hr_p), .hires_duty_en(hr_d));
  // Xorshift source of register data
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // Bits that each register keeps
  function automatic logic [15:0] mask(input int i);
    case (i)
      0: return PFBC_MASK_FULL;
      4: return 16'h0000;
      5: return PFBC_MASK_CHOP;
      6: return PFBC_MASK_AUX;
      7: return PFBC_MASK_OUT_DATA;
      default: return PFBC_MASK_UPPER13;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk) begin
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge core_clk) reg_wr <= 0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk) begin
      reg_rd <= 1;
      reg_addr <= a;
    end
    @(posedge core_clk) reg_rd <= 0;
    #1 rdv = reg_rdata;
  endtask
  // Count the high cycles of each output over n cycles
  task automatic run(input int n);
    c_hi = 0;
    c_lo = 0;
    c_p = 0;
    c_s = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      c_hi += int'(high_output);
      c_lo += int'(low_output);
      c_p += int'(trg_p);
      c_s += int'(trg_s);
    end
  endtask
  // Wait for the next period start, bounded
  task automatic sync();
    int k;
    repeat (2) @(posedge core_clk);
    #1;
    for (k = 0; k < 100 && ps !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  // Both outputs high means the fault data drives them
  task automatic forced(input logic exp);
    repeat (3) @(posedge core_clk);
    #1 check(16'(high_output & low_output), 16'(exp));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    int s;
    logic [15:0] v;
    repeat (5) @(posedge core_clk);
    reset <= 0;
    // Highest index first: the random control word lands last
    for (s = 7; s >= 0; s--) begin
      rd(3'(s));
      check(rdv, PFBC_RST_REG);
      v = xs();
      wr(3'(s), v);
      rd(3'(s));
      check(rdv, v & mask(s));
    end
    wr(0, 16'h0003);
    wr(3, 16'h0000);
    wr(5, 16'h0000);
    wr(6, 16'hc000);
    #1 check(16'({hr_p, hr_d}), 16'h0003);
    wr(6, 16'h4000);
    #1 check(16'({hr_p, hr_d}), 16'h0001);
    $display("test registers done");
    wr(7, 16'h0003);
    for (s = 0; s < 9; s++) begin
      wr(0, 16'(s * 8 + 1));
      @(posedge core_clk) fault_drive <= (s < 8) ? 8'h01 << s : 8'hff;
      forced(s < 8);
      @(posedge core_clk) fault_drive <= 0;
      sync();
      forced(0);
    end
    wr(0, 16'h0000);
    @(posedge core_clk) fault_drive <= 1;
    forced(1);
    @(posedge core_clk) fault_drive <= 0;
    sync();
    forced(1);
    wr(0, 16'h0003);
    @(posedge core_clk) fault_drive <= 1;
    forced(0);
    // Polarity changes only while the fault line is idle
    @(posedge core_clk) fault_drive <= 8'hff;
    wr(0, 16'h0005);
    forced(0);
    @(posedge core_clk) fault_drive <= 8'hfe;
    forced(1);
    @(posedge core_clk) fault_drive <= 8'hff;
    wr(0, 16'h0003);
    $display("test faults done");
    wr(1, 16'h0018);
    wr(2, 16'h0028);
    @(posedge core_clk) begin
      loc_p <= 1;
      loc_s <= 1;
    end
    sync();
    run(256);
    check(16'(c_p), 16'h0004);
    check(16'(c_s), 16'h0004);
    @(posedge core_clk) begin
      loc_p <= 0;
      loc_s <= 0;
    end
    run(256);
    check(16'(c_p + c_s), 16'h0000);
    $display("test triggers done");
    // Limit rises inside a two-cycle window after the fall at count 22
    wr(3, 16'h4410);
    @(posedge core_clk) fault_drive <= 8'h00;
    sync();
    repeat (23) @(posedge core_clk);
    fault_drive <= 8'h01;
    repeat (4) @(posedge core_clk);
    rd(4);
    check(rdv, 16'h0018);
    wr(3, 16'h0000);
    $display("test capture done");
    // Input one as limit, fault selector moved to an idle input
    wr(7, 16'h0002);
    wr(0, 16'h8139);
    run(64);
    check(16'(c_hi), 16'h0040);
    check(16'(c_lo), 16'h002a);
    // Input one as fault, limit selector moved to an idle input
    wr(0, 16'h0003);
    wr(7, 16'h0001);
    wr(0, 16'h9d01);
    run(64);
    check(16'(c_hi), 16'h0016);
    check(16'(c_lo), 16'h0040);
    wr(0, 16'h0003);
    $display("test independent done");
    wr(6, 16'h0006);
    run(64);
    check(16'(c_hi), 16'h0000);
    check(16'(c_lo), 16'h002a);
    @(posedge core_clk) chop_peer <= 3'h1;
    run(64);
    check(16'(c_hi), 16'h0016);
    wr(6, 16'h0002);
    run(64);
    check(16'(c_hi), 16'h0000);
    wr(5, 16'h8000);
    run(64);
    check(16'(c_hi), 16'h000b);
    $display("test chop done");
    final_report();
  end
  // Whole run needs under 2000 cycles; cut a hang well beyond that
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule
